// File: verilog/ppo_pkg.sv
// Package with register map, field positions, timing and carrier types for the port pin block
`default_nettype none
package ppo_pkg;
	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_PA_INPUT = 7'h00;
	localparam logic [6:0] IDX_PA_DIR = 7'h01;
	localparam logic [6:0] IDX_PA_LATCH = 7'h02;
	localparam logic [6:0] IDX_PB_LATCH = 7'h05;
	localparam logic [6:0] IDX_SYSCTL = 7'h35;
	localparam logic [6:0] IDX_PD_DIR = 7'h40;
	localparam logic [6:0] IDX_PD_LATCH = 7'h41;
	localparam logic [6:0] IDX_IRQ_STATUS = 7'h42;
	localparam logic [6:0] IDX_IRQ_MASK = 7'h43;

	// System control fields
	localparam int SC_DEBUG_DIS = 7;
	localparam int SC_PULLUP_DIS = 4;
	localparam int SC_VEC_SEL = 1;
	localparam int SC_VEC_CHG = 0;
	localparam logic [7:0] SC_WRITABLE = 8'h93;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// Port D bit positions of alternate functions
	localparam int PD_RX = 0;
	localparam int PD_TX = 1;
	localparam int PD_EXT0 = 2;
	localparam int PD_EXT1 = 3;
	localparam int PD_CAPTURE = 6;
	localparam int PD_CMP_LO = 4;

	// Timing: clock period and spike filter width
	localparam int CLK_PERIOD_NS = 50;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Peripheral requests arriving at the port
	typedef struct packed {
		logic serial_tx_enable;
		logic serial_rx_enable;
		logic serial_tx_data;
		logic two_wire_enable;
		logic [3:0] cmp_enable;
		logic [3:0] cmp_level;
		logic [7:0] pin_change_mask;
		logic pin_change_group3_enable;
		logic [1:0] ext_irq_enable;
	} ppo_periph_t;

	// Pin levels delivered to the peripherals
	typedef struct packed {
		logic [7:0] pin_change_src;
		logic ext_irq_zero;
		logic ext_irq_one;
		logic timer1_capture_in;
		logic serial_rx_data;
		logic [1:0] two_wire_in;
	} ppo_sense_t;
endpackage : ppo_pkg
`default_nettype wire

// File: verilog/ppo_port_top.sv
// Port pin override logic, port registers and Avalon-MM register slave
`default_nettype none
module ppo_port_top #(
	parameter int WIDTH = 8,
	parameter int FILT_CYCLES = ppo_pkg::SPIKE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [WIDTH-1:0] pa_in,
	output logic [WIDTH-1:0] pa_out,
	output logic [WIDTH-1:0] pa_oe,
	output logic [WIDTH-1:0] pa_pullup,
	output logic [WIDTH-1:0] pb_latch,
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic [7:0] pd_oe,
	output logic [7:0] pd_pullup,
	input wire logic input_sleep_gate,
	input wire ppo_pkg::ppo_periph_t periph,
	output ppo_pkg::ppo_sense_t sense,
	output logic debug_port_disable,
	output logic vector_table_select,
	output logic vector_change_enable,
	output logic irq
);
	import ppo_pkg::*;

	logic [WIDTH-1:0] pa_dir_q;
	logic [WIDTH-1:0] pa_latch_q;
	logic [WIDTH-1:0] pa_in_q;
	logic [WIDTH-1:0] pb_latch_q;
	logic [7:0] pd_dir_q;
	logic [7:0] pd_latch_q;
	logic [7:0] sysctl_q;
	logic [7:0] irq_status_q;
	logic [7:0] irq_mask_q;
	logic [31:0] rdata_q;
	logic ack_q;
	logic req;
	logic wr_fire;
	logic lane0;
	logic global_pullup_disable;
	logic [7:0] pullup_override_en;
	logic [7:0] pullup_override_val;
	logic [7:0] dir_override_en;
	logic [7:0] dir_override_val;
	logic [7:0] pin_value_override_en;
	logic [7:0] pin_value_override_val;
	logic [7:0] input_enable_override_en;
	logic [7:0] input_enable_override_val;
	logic [7:0] pd_dir_eff;
	logic [7:0] pd_in_en;
	logic [7:0] pd_di;
	logic [7:0] pd_di_prev_q;
	logic armed_q;
	logic [7:0] pc_event;
	logic [1:0] tw_filt;

	// Bus handshake: one wait cycle, then the answer stands for one cycle
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_fire = avs_write & ack_q;
	assign lane0 = avs_byteenable[0];
	assign avs_readdata = rdata_q;

	// Ack pulses once per request so back-to-back requests each wait
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Input levels sampled every cycle, no reset value
	always_ff @(posedge mclk) begin
		pa_in_q <= pa_in;
	end

	// Read data captured during the wait cycle; unmapped reads give zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= RST_WORD;
		end else if (avs_read & ~ack_q) begin
			rdata_q <= RST_WORD;
			unique case (avs_address)
				IDX_PA_INPUT: rdata_q[WIDTH-1:0] <= pa_in_q;
				IDX_PA_DIR: rdata_q[WIDTH-1:0] <= pa_dir_q;
				IDX_PA_LATCH: rdata_q[WIDTH-1:0] <= pa_latch_q;
				IDX_PB_LATCH: rdata_q[WIDTH-1:0] <= pb_latch_q;
				IDX_SYSCTL: rdata_q[7:0] <= sysctl_q & SC_WRITABLE;
				IDX_PD_DIR: rdata_q[7:0] <= pd_dir_q;
				IDX_PD_LATCH: rdata_q[7:0] <= pd_latch_q;
				IDX_IRQ_STATUS: rdata_q[7:0] <= irq_status_q;
				IDX_IRQ_MASK: rdata_q[7:0] <= irq_mask_q;
				default: rdata_q <= RST_WORD;
			endcase
		end
	end

	// Port A registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			pa_dir_q <= '0;
			pa_latch_q <= '0;
		end else if (wr_fire & lane0) begin
			if (avs_address == IDX_PA_DIR) begin
				pa_dir_q <= avs_writedata[WIDTH-1:0];
			end
			if (avs_address == IDX_PA_LATCH) begin
				pa_latch_q <= avs_writedata[WIDTH-1:0];
			end
		end
	end

	// Port B latch
	always_ff @(posedge mclk) begin
		if (rst) begin
			pb_latch_q <= '0;
		end else if (wr_fire & lane0 & (avs_address == IDX_PB_LATCH)) begin
			pb_latch_q <= avs_writedata[WIDTH-1:0];
		end
	end

	// Port D direction and latch
	always_ff @(posedge mclk) begin
		if (rst) begin
			pd_dir_q <= RST_BYTE;
			pd_latch_q <= RST_BYTE;
		end else if (wr_fire & lane0) begin
			if (avs_address == IDX_PD_DIR) begin
				pd_dir_q <= avs_writedata[7:0];
			end
			if (avs_address == IDX_PD_LATCH) begin
				pd_latch_q <= avs_writedata[7:0];
			end
		end
	end

	// System control; unused bits never store, so they read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			sysctl_q <= RST_BYTE;
		end else if (wr_fire & lane0 & (avs_address == IDX_SYSCTL)) begin
			sysctl_q <= avs_writedata[7:0] & SC_WRITABLE;
		end
	end

	assign global_pullup_disable = sysctl_q[SC_PULLUP_DIS];
	assign debug_port_disable = sysctl_q[SC_DEBUG_DIS];
	assign vector_table_select = sysctl_q[SC_VEC_SEL];
	assign vector_change_enable = sysctl_q[SC_VEC_CHG];

	// Port A has no alternate function: plain register path
	always_comb begin
		pa_oe = pa_dir_q;
		pa_out = pa_latch_q;
		pa_pullup = ~pa_dir_q & pa_latch_q & {WIDTH{~global_pullup_disable}};
	end
	assign pb_latch = pb_latch_q;

	// Override table for port D, bits 7..4
	always_comb begin
		for (int i = 4; i < 8; i++) begin
			pullup_override_en[i] = 1'b0;
			pullup_override_val[i] = 1'b0;
			dir_override_en[i] = 1'b0;
			dir_override_val[i] = 1'b0;
			pin_value_override_en[i] = periph.cmp_enable[i-PD_CMP_LO];
			pin_value_override_val[i] = periph.cmp_level[i-PD_CMP_LO];
			input_enable_override_en[i] = periph.pin_change_mask[i] & periph.pin_change_group3_enable;
			input_enable_override_val[i] = 1'b1;
		end
		// Bits 3..0: interrupt sources keep the input readable in sleep
		for (int i = 0; i < 4; i++) begin
			input_enable_override_en[i] = periph.pin_change_mask[i] & periph.pin_change_group3_enable;
			input_enable_override_val[i] = 1'b1;
			pin_value_override_en[i] = 1'b0;
			pin_value_override_val[i] = 1'b0;
			pullup_override_en[i] = 1'b0;
			pullup_override_val[i] = 1'b0;
			dir_override_en[i] = 1'b0;
			dir_override_val[i] = 1'b0;
		end
		input_enable_override_en[PD_EXT0] = input_enable_override_en[PD_EXT0] | periph.ext_irq_enable[0];
		input_enable_override_en[PD_EXT1] = input_enable_override_en[PD_EXT1] | periph.ext_irq_enable[1];
		// Transmitter owns bit 1 as an output
		pullup_override_en[PD_TX] = periph.serial_tx_enable;
		pullup_override_val[PD_TX] = pd_latch_q[PD_TX] & ~global_pullup_disable;
		dir_override_en[PD_TX] = periph.serial_tx_enable;
		dir_override_val[PD_TX] = 1'b1;
		pin_value_override_en[PD_TX] = periph.serial_tx_enable;
		pin_value_override_val[PD_TX] = periph.serial_tx_data;
		// Receiver owns bit 0 as an input, pull-up still from the latch
		pullup_override_en[PD_RX] = periph.serial_rx_enable;
		pullup_override_val[PD_RX] = pd_latch_q[PD_RX] & ~global_pullup_disable;
		dir_override_en[PD_RX] = periph.serial_rx_enable;
		dir_override_val[PD_RX] = 1'b0;
	end

	// Generic pin: overrides win, otherwise register path
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pd_dir_eff[i] = dir_override_en[i] ? dir_override_val[i] : pd_dir_q[i];
			pd_out[i] = pin_value_override_en[i] ? pin_value_override_val[i] : pd_latch_q[i];
			pd_pullup[i] = pullup_override_en[i] ? pullup_override_val[i]
				: (~pd_dir_eff[i] & pd_latch_q[i] & ~global_pullup_disable);
			pd_in_en[i] = input_enable_override_en[i] ? input_enable_override_val[i] : ~input_sleep_gate;
		end
		// Compare outputs drive only when direction is output
		pd_oe = pd_dir_eff;
		pd_di = pd_in & pd_in_en;
	end

	// Spike filter on the two-wire inputs; a pulse must last FILT_CYCLES
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tw_filter
			logic filt_q;
			logic [3:0] cnt_q;
			always_ff @(posedge mclk) begin
				if (rst) begin
					filt_q <= 1'b0;
					cnt_q <= 4'h0;
				end else if (pd_di[g] == filt_q) begin
					cnt_q <= 4'h0;
				end else if (cnt_q >= 4'(FILT_CYCLES - 1)) begin
					filt_q <= pd_di[g];
					cnt_q <= 4'h0;
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
			// Bypass when the two-wire unit is off, keeps latency zero for other users
			assign tw_filt[g] = periph.two_wire_enable ? filt_q : pd_di[g];
		end
	endgenerate

	// Pin levels to the peripherals
	always_comb begin
		sense.pin_change_src = pd_di;
		sense.ext_irq_zero = pd_di[PD_EXT0];
		sense.ext_irq_one = pd_di[PD_EXT1];
		sense.timer1_capture_in = pd_di[PD_CAPTURE];
		sense.serial_rx_data = pd_di[PD_RX];
		sense.two_wire_in = tw_filt;
	end

	// Previous input levels; armed_q hides the first cycle after reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			pd_di_prev_q <= RST_BYTE;
			armed_q <= 1'b0;
		end else begin
			pd_di_prev_q <= pd_di;
			armed_q <= 1'b1;
		end
	end
	assign pc_event = (pd_di ^ pd_di_prev_q) & {8{armed_q}};

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_status_q <= RST_BYTE;
		end else if (wr_fire & lane0 & (avs_address == IDX_IRQ_STATUS)) begin
			irq_status_q <= (irq_status_q & ~avs_writedata[7:0]) | pc_event;
		end else begin
			irq_status_q <= irq_status_q | pc_event;
		end
	end

	// Interrupt mask
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_mask_q <= RST_BYTE;
		end else if (wr_fire & lane0 & (avs_address == IDX_IRQ_MASK)) begin
			irq_mask_q <= avs_writedata[7:0];
		end
	end

	assign irq = |(irq_status_q & irq_mask_q);

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_cmp_needs_dir;
		(!dir_override_en[7] && !pd_dir_q[7]) |-> !pd_oe[7] ##1 (pd_dir_q[7] || !pd_oe[7]);
	endproperty
	a_cmp_needs_dir: assert property (p_cmp_needs_dir) else $error("compare pin driven without direction");

	property p_cmp_value;
		(periph.cmp_enable[1] && pd_dir_q[5]) |-> (pd_oe[5] && pd_out[5] == periph.cmp_level[1]);
	endproperty
	a_cmp_value: assert property (p_cmp_value) else $error("compare level not on pin 5");

	property p_tx_forced;
		periph.serial_tx_enable |-> (pd_oe[PD_TX] && pd_out[PD_TX] == periph.serial_tx_data);
	endproperty
	a_tx_forced: assert property (p_tx_forced) else $error("tx pin not forced output");

	property p_rx_forced;
		periph.serial_rx_enable |-> (!pd_oe[PD_RX] && pd_pullup[PD_RX] == (pd_latch_q[PD_RX] && !global_pullup_disable));
	endproperty
	a_rx_forced: assert property (p_rx_forced) else $error("rx pin not input with latch pull-up");

	property p_pud_all_off;
		global_pullup_disable |-> (pd_pullup == 8'h00 && pa_pullup == '0);
	endproperty
	a_pud_all_off: assert property (p_pud_all_off) else $error("pull-up active while disabled");

	property p_sysctl_write;
		(wr_fire && lane0 && avs_address == IDX_SYSCTL) |=>
			(sysctl_q == ($past(avs_writedata[7:0]) & SC_WRITABLE));
	endproperty
	a_sysctl_write: assert property (p_sysctl_write) else $error("system control write lost");

	property p_dir_write;
		(wr_fire && lane0 && avs_address == IDX_PA_DIR) |=> (pa_dir_q == $past(avs_writedata[WIDTH-1:0]));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("port A direction write lost");

	property p_port_a_input_levels_read;
		(avs_read && avs_waitrequest && avs_address == IDX_PA_INPUT) |=>
			(!avs_waitrequest && avs_readdata[WIDTH-1:0] == $past(pa_in_q));
	endproperty
	a_port_a_input_levels_read: assert property (p_port_a_input_levels_read) else $error("input read wrong or late");

	// Second cycle may legally see a software clear of the bit
	property p_pc_sticky;
		(armed_q && pd_di[3] != pd_di_prev_q[3]) |=> irq_status_q[3] ##1
			(irq_status_q[3] || $past(wr_fire && lane0 && avs_address == IDX_IRQ_STATUS && avs_writedata[3]));
	endproperty
	a_pc_sticky: assert property (p_pc_sticky) else $error("pin change not latched");

	property p_capture_path;
		pd_in_en[PD_CAPTURE] |-> (sense.timer1_capture_in == pd_in[PD_CAPTURE]);
	endproperty
	a_capture_path: assert property (p_capture_path) else $error("capture input not fed");

	// A one-cycle excursion from a settled level must leave the output alone
	property p_filter_holds;
		(periph.two_wire_enable && tw_filt[0] == pd_di[0]) ##1 (periph.two_wire_enable && tw_filt[0] != pd_di[0])
			##1 (periph.two_wire_enable && $changed(pd_di[0])) |-> ($stable(tw_filt[0]) || FILT_CYCLES <= 1);
	endproperty
	a_filter_holds: assert property (p_filter_holds) else $error("spike passed the filter");

	c_tx_active: cover property (periph.serial_tx_enable && pd_oe[PD_TX]);
	c_rx_pullup: cover property (periph.serial_rx_enable && pd_pullup[PD_RX]);
	c_irq_raised: cover property (!irq ##1 irq);
	c_bus_write: cover property (wr_fire && avs_address == IDX_SYSCTL);
endmodule : ppo_port_top
`default_nettype wire

// File: verification/ppo_pin_model.sv
// Pad model: resolves pin levels from device drive, pull-ups and outside drivers
`default_nettype none
module ppo_pin_model #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic [W-1:0] dev_out,
	input wire logic [W-1:0] dev_oe,
	input wire logic [W-1:0] dev_pu,
	input wire logic [W-1:0] ext_en,
	input wire logic [W-1:0] ext_val,
	output logic [W-1:0] pad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] drift_q = '0;

	// Floating pads wander so a stale level is never mistaken for a real one
	always_ff @(posedge mclk) begin
		drift_q <= ~drift_q;
	end

	// Device drive first, then outside driver, then pull-up or drift
	assign pad = (dev_oe & dev_out) | (~dev_oe & ext_en & ext_val) | (~dev_oe & ~ext_en & (dev_pu | drift_q));
endmodule : ppo_pin_model
`default_nettype wire

// File: verification/test_port_pin_override_and_regs.sv
// Self-checking bench for the port pin override and register block
`default_nettype none
module test_port_pin_override_and_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import ppo_pkg::*;
	localparam int FILT = 2;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] pa_in, pa_out, pa_oe, pa_pullup, pb_latch, pd_in, pd_out, pd_oe, pd_pullup;
	logic input_sleep_gate = 1'b0;
	ppo_periph_t periph = '0;
	ppo_sense_t sense;
	logic dbg_dis, vec_sel, vec_chg, irq;
	logic [7:0] a_en = '0, a_val = '0, d_en = '0, d_val = '0;
	logic [15:0] lf = 16'h0025;
	logic [6:0] idx [6] = '{IDX_PA_DIR, IDX_PA_LATCH, IDX_PB_LATCH, IDX_SYSCTL, IDX_PD_DIR, IDX_PD_LATCH};
	int num_errors = 0;
	int n_checks = 0;

	// Free-running system clock
	always #25 mclk = ~mclk;

	ppo_port_top #(.FILT_CYCLES(FILT)) dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .pb_latch(pb_latch),
		.pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pullup(pd_pullup),
		.input_sleep_gate(input_sleep_gate), .periph(periph), .sense(sense), .debug_port_disable(dbg_dis),
		.vector_table_select(vec_sel), .vector_change_enable(vec_chg), .irq(irq));
	ppo_pin_model pa_pads (.mclk(mclk), .dev_out(pa_out), .dev_oe(pa_oe), .dev_pu(pa_pullup),
		.ext_en(a_en), .ext_val(a_val), .pad(pa_in));
	ppo_pin_model pd_pads (.mclk(mclk), .dev_out(pd_out), .dev_oe(pd_oe), .dev_pu(pd_pullup),
		.ext_en(d_en), .ext_val(d_val), .pad(pd_in));

	// Eight LFSR steps per byte, seeded at 37
	function automatic logic [7:0] rb();
		repeat (8) lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction : rb

	// Expected port D {out, oe} after alternate-function overrides
	function automatic logic [15:0] pd_exp(input logic [7:0] dir, input logic [7:0] lat, input ppo_periph_t p);
		logic [7:0] o, e;
		o = lat;
		e = dir;
		for (int i = 4; i < 8; i++)
			o[i] = p.cmp_enable[i-4] ? p.cmp_level[i-4] : lat[i];
		if (p.serial_tx_enable) begin
			e[1] = 1'b1;
			o[1] = p.serial_tx_data;
		end
		if (p.serial_rx_enable)
			e[0] = 1'b0;
		return {o, e};
	endfunction : pd_exp

	// Expected digital input enables for port D
	function automatic logic [7:0] ie_exp(input ppo_periph_t p, input logic slp);
		logic [7:0] v;
		v = p.pin_change_mask & {8{p.pin_change_group3_enable}};
		v[3:2] = v[3:2] | p.ext_irq_enable;
		return v | {8{~slp}};
	endfunction : ie_exp

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One Avalon transfer; held until waitrequest is seen low at a rising edge, data taken there
	task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h0, d};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			@(posedge mclk);
			n++;
		end
		if (n == 40)
			chk("waitrequest", 1, 0);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, q, e);
	endtask : rd_chk

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// Hang guard, far beyond the roughly 700 cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		final_report();
	end

	// Main test sequence
	initial begin
		logic [7:0] dir, lat, sc, av, pv, m, e_oe, e_pi;
		logic [15:0] pe;
		logic [23:0] t;
		logic slp;
		ppo_periph_t p;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		foreach (idx[i]) rd_chk("reset", idx[i], 8'h00);
		chk("pb_reset", pb_latch, 0);
		$display("reset test done");
		wr(IDX_SYSCTL, 8'hff);
		rd_chk("sysctl", IDX_SYSCTL, 8'h93);
		chk("sc_bits", {dbg_dis, vec_sel, vec_chg}, 3'b111);
		wr(7'h10, 8'hff);
		rd_chk("unmapped", 7'h10, 8'h00);
		$display("control test done");
		// Random registers, overrides and pad levels
		for (int k = 0; k < 24; k++) begin
			dir = rb();
			lat = rb();
			sc = rb() & 8'h10;
			wr(IDX_PA_DIR, dir);
			wr(IDX_PA_LATCH, lat);
			wr(IDX_PB_LATCH, lat ^ dir);
			wr(IDX_SYSCTL, sc);
			wr(IDX_PD_DIR, dir);
			wr(IDX_PD_LATCH, lat);
			t = {rb(), rb(), rb()};
			p = t[22:0];
			p.two_wire_enable = 1'b0;
			pe = pd_exp(dir, lat, p);
			e_oe = pe[7:0];
			av = rb();
			pv = rb();
			slp = lf[3];
			@(posedge mclk);
			periph <= p;
			input_sleep_gate <= slp;
			a_en <= ~dir;
			a_val <= av;
			d_en <= ~e_oe;
			d_val <= pv;
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			m = p.serial_tx_enable ? 8'hfd : 8'hff;
			e_pi = ((e_oe & pe[15:8]) | (~e_oe & pv)) & ie_exp(p, slp);
			chk("pa_oe", pa_oe, dir);
			chk("pa_out", pa_out, lat);
			chk("pb_latch", pb_latch, lat ^ dir);
			chk("pa_pullup", pa_pullup, ~dir & lat & {8{~sc[4]}});
			chk("pd_oe", pd_oe, e_oe);
			chk("pd_out", pd_out & e_oe, pe[15:8] & e_oe);
			chk("pd_pullup", pd_pullup & m, ~e_oe & lat & {8{~sc[4]}} & m);
			chk("pc_src", sense.pin_change_src, e_pi);
			chk("sense", {sense.ext_irq_one, sense.ext_irq_zero, sense.timer1_capture_in, sense.serial_rx_data},
				{e_pi[3], e_pi[2], e_pi[6], e_pi[0]});
			chk("irq_masked", irq, 0);
			rd_chk("pa_in", IDX_PA_INPUT, (dir & lat) | (~dir & av));
		end
		$display("override test done");
		// Pin-change interrupt: raise, mask, clear
		wr(IDX_PD_DIR, 8'h00);
		@(posedge mclk);
		periph <= '0;
		input_sleep_gate <= 1'b0;
		d_en <= 8'hff;
		d_val <= 8'h00;
		repeat (3) @(posedge mclk);
		wr(IDX_IRQ_STATUS, 8'hff);
		wr(IDX_IRQ_MASK, 8'h04);
		rd_chk("status_clr", IDX_IRQ_STATUS, 8'h00);
		@(posedge mclk);
		d_val <= 8'h04;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("irq_set", irq, 1);
		rd_chk("status", IDX_IRQ_STATUS, 8'h04);
		wr(IDX_IRQ_MASK, 8'h00);
		@(negedge mclk);
		chk("irq_mask", irq, 0);
		wr(IDX_IRQ_MASK, 8'h04);
		@(negedge mclk);
		chk("irq_unmask", irq, 1);
		wr(IDX_IRQ_STATUS, 8'h04);
		@(negedge mclk);
		chk("irq_clr", irq, 0);
		$display("interrupt test done");
		// Two-wire spike filter: a one-cycle spike must not pass
		@(posedge mclk);
		periph.two_wire_enable <= 1'b1;
		repeat (FILT + 4) @(posedge mclk);
		@(negedge mclk);
		chk("tw_low", sense.two_wire_in[0], 0);
		@(posedge mclk);
		d_val[0] <= 1'b1;
		@(posedge mclk);
		d_val[0] <= 1'b0;
		repeat (4) begin
			@(negedge mclk);
			chk("tw_spike", sense.two_wire_in[0], 0);
		end
		@(posedge mclk);
		d_val[0] <= 1'b1;
		repeat (FILT + 3) @(posedge mclk);
		@(negedge mclk);
		chk("tw_high", sense.two_wire_in[0], 1);
		@(posedge mclk);
		periph.two_wire_enable <= 1'b0;
		d_val[0] <= 1'b0;
		@(negedge mclk);
		chk("tw_bypass", sense.two_wire_in[0], 0);
		$display("filter test done");
		final_report();
	end
endmodule : test_port_pin_override_and_regs
`default_nettype wire
